//--- rtl/lpws_pkg.sv
// Package: constants and types of the low-power wakeup time selector
package lpws_pkg;

    // =========================================================
    // Sizes
    localparam int NUM_FSP    = 3;
    localparam int NUM_TIMES  = 8;
    localparam int NUM_STATES = 5;
    localparam int TIME_W     = 8;
    localparam int ADDR_W     = 12;

    // =========================================================
    // Register byte offsets
    localparam logic [11:0] CTRL_OFS   = 12'h000;
    localparam logic [11:0] STATUS_OFS = 12'h004;
    localparam logic [11:0] WAKE_BASE  = 12'h100;
    localparam logic [11:0] FSP_STRIDE = 12'h020;

    // =========================================================
    // Control word fields
    localparam int EN_LSB     = 24;
    localparam int EN_MSB     = 29;
    localparam int FSP_LSB    = 0;
    localparam int FSP_MSB    = 1;
    localparam logic [5:0] EN_RESET  = 6'h00;
    localparam logic [1:0] FSP_RESET = 2'h0;
    localparam logic [7:0] TIME_RESET = 8'h00;

    // Status word fields
    localparam int ST_PAT_BIT   = 0;
    localparam int ST_ORD_LSB   = 1;
    localparam int ST_LAST_LSB  = 8;

    // =========================================================
    // Wakeup time index within one set point
    localparam logic [2:0] T_IDLE     = 3'h0;
    localparam logic [2:0] T_PD       = 3'h1;
    localparam logic [2:0] T_SR_SHORT = 3'h2;
    localparam logic [2:0] T_SR_LONG  = 3'h3;
    localparam logic [2:0] T_SRPD_SH  = 3'h4;
    localparam logic [2:0] T_SRPD_LG  = 3'h5;
    localparam logic [2:0] T_CLKGATE  = 3'h6;
    localparam logic [2:0] T_TIMER    = 3'h7;

    // Register access kind found by the address decoder
    typedef enum logic [1:0] {
        LPWS_ACC_NONE,
        LPWS_ACC_CTRL,
        LPWS_ACC_STATUS,
        LPWS_ACC_WAKE
    } lpws_acc_t;

    typedef struct packed {
        lpws_acc_t   acc;
        logic [1:0]  fsp;
        logic [2:0]  idx;
    } lpws_dec_t;

    // Result handed to the low-power sequencer
    typedef struct packed {
        logic              valid;
        logic              enabled;
        logic [TIME_W-1:0] wake_time;
    } lpws_wake_t;

endpackage

//--- rtl/lpws_wakeup_select.sv
// Low-power wakeup time selector with APB register file and checker
//
// Overview of operation
// [R1] Enable field sits at bits 29..24 of the control word, one per state.
// [R2] Enable bits 0..4 name states from shallowest to deepest.
// [R3] Software setting one enable must also set all deeper enables.
// [R4] Applied time shrinks when next deeper state disabled or lower.
// [R5] Software programs wakeup times strictly increasing by state depth.
// [R6] Idle=bit0, pd=bit1, four sr=bit2, clock gated=bit3, timer=bit4.
// [R7] Each wakeup time has a copy per set point; active copy applies.
// [R8] Checker flags broken enable pattern and non increasing times.
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/1ps
module lpws_wakeup_select (
    // Clock and reset
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    // APB slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [11:0]                paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata_ff,
    output logic                            pready_ff,
    output logic                            pslverr_ff,
    // Low-power entry request from the sequencer
    input  wire logic                       lp_req,
    input  wire logic [2:0]                 lp_kind,
    // Selected wakeup time and checker result
    output lpws_pkg::lpws_wake_t            wake_out_ff,
    output logic                            cfg_err_ff
);

    // =========================================================
    // Storage
    logic [5:0]                  enable_ff;
    logic [1:0]                  fsp_ff;
    logic [lpws_pkg::TIME_W-1:0] wake_ff [lpws_pkg::NUM_FSP]
                                         [lpws_pkg::NUM_TIMES];
    logic [lpws_pkg::NUM_FSP-1:0] ord_err;
    logic                        pat_err;
    logic                        access;
    lpws_pkg::lpws_dec_t         dec;

    // =========================================================
    // Helpers
    // Enable bit that governs a wakeup time index
    function automatic logic [2:0] group_of(input logic [2:0] idx);
        if (idx == lpws_pkg::T_IDLE)         group_of = 3'h0; // see [R6]
        else if (idx == lpws_pkg::T_PD)      group_of = 3'h1;
        else if (idx == lpws_pkg::T_CLKGATE) group_of = 3'h3;
        else if (idx == lpws_pkg::T_TIMER)   group_of = 3'h4;
        else                                 group_of = 3'h2;
    endfunction

    // First wakeup time index of a group
    function automatic logic [2:0] group_start(input logic [2:0] g);
        case (g)
            3'h0:    group_start = lpws_pkg::T_IDLE;
            3'h1:    group_start = lpws_pkg::T_PD;
            3'h2:    group_start = lpws_pkg::T_SR_SHORT;
            3'h3:    group_start = lpws_pkg::T_CLKGATE;
            default: group_start = lpws_pkg::T_TIMER;
        endcase
    endfunction

    // Wakeup time applied, including the dependency on the deeper state
    function automatic logic [lpws_pkg::TIME_W-1:0] eff_time(
        input logic [1:0] fsp,
        input logic [2:0] idx
    );
        logic [2:0]                  g;
        logic [lpws_pkg::TIME_W-1:0] own;
        logic [lpws_pkg::TIME_W-1:0] deeper;
        g      = group_of(idx);
        own    = wake_ff[fsp][idx];
        deeper = wake_ff[fsp][group_start(3'(g + 3'h1))];
        if (g == 3'h4)                 eff_time = own;
        else if (!enable_ff[g + 3'h1]) eff_time = own >> 1; // see [R4]
        else if (deeper < own)         eff_time = deeper;   // see [R4]
        else                           eff_time = own;
    endfunction

    // Address decode, used by both the write and the read path
    function automatic lpws_pkg::lpws_dec_t decode(input logic [11:0] a);
        logic [11:0] rel;
        decode.acc = lpws_pkg::LPWS_ACC_NONE;
        decode.fsp = 2'h0;
        decode.idx = 3'h0;
        rel = a - lpws_pkg::WAKE_BASE;
        if (a == lpws_pkg::CTRL_OFS) begin
            decode.acc = lpws_pkg::LPWS_ACC_CTRL;
        end else if (a == lpws_pkg::STATUS_OFS) begin
            decode.acc = lpws_pkg::LPWS_ACC_STATUS;
        end else if (a >= lpws_pkg::WAKE_BASE && a[1:0] == 2'h0
                     && rel < 12'(lpws_pkg::NUM_FSP) * lpws_pkg::FSP_STRIDE)
        begin
            decode.acc = lpws_pkg::LPWS_ACC_WAKE;
            decode.fsp = rel[6:5];
            decode.idx = rel[4:2];
        end
    endfunction

    assign dec    = decode(paddr);
    assign access = psel && penable && pready_ff;

    // =========================================================
    // APB handshake: one wait state, then the access completes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff  <= psel && penable && !pready_ff;
            pslverr_ff <= psel && penable && !pready_ff
                          && dec.acc == lpws_pkg::LPWS_ACC_NONE;
        end
    end

    // =========================================================
    // Control word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_ff <= lpws_pkg::EN_RESET;
            fsp_ff    <= lpws_pkg::FSP_RESET;
        end else if (access && pwrite
                     && dec.acc == lpws_pkg::LPWS_ACC_CTRL) begin
            enable_ff <= pwdata[lpws_pkg::EN_MSB:lpws_pkg::EN_LSB]; // see [R1]
            if (pwdata[lpws_pkg::FSP_MSB:lpws_pkg::FSP_LSB] != 2'h3) begin
                fsp_ff <= pwdata[lpws_pkg::FSP_MSB:lpws_pkg::FSP_LSB];
            end
        end
    end

    // =========================================================
    // Wakeup time copies, one bank per set point
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int f = 0; f < lpws_pkg::NUM_FSP; f++) begin
                for (int t = 0; t < lpws_pkg::NUM_TIMES; t++) begin
                    wake_ff[f][t] <= lpws_pkg::TIME_RESET;
                end
            end
        end else if (access && pwrite
                     && dec.acc == lpws_pkg::LPWS_ACC_WAKE) begin
            wake_ff[dec.fsp][dec.idx] <=
                pwdata[lpws_pkg::TIME_W-1:0]; // see [R7]
        end
    end

    // =========================================================
    // Read data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
        end else if (psel && penable && !pready_ff && !pwrite) begin
            prdata_ff <= 32'h0000_0000;
            if (dec.acc == lpws_pkg::LPWS_ACC_CTRL) begin
                prdata_ff[lpws_pkg::EN_MSB:lpws_pkg::EN_LSB]   <= enable_ff;
                prdata_ff[lpws_pkg::FSP_MSB:lpws_pkg::FSP_LSB] <= fsp_ff;
            end else if (dec.acc == lpws_pkg::LPWS_ACC_STATUS) begin
                prdata_ff[lpws_pkg::ST_PAT_BIT] <= pat_err;
                prdata_ff[lpws_pkg::ST_ORD_LSB +: lpws_pkg::NUM_FSP] <=
                    ord_err;
                prdata_ff[lpws_pkg::ST_LAST_LSB +: lpws_pkg::TIME_W] <=
                    wake_out_ff.wake_time;
            end else if (dec.acc == lpws_pkg::LPWS_ACC_WAKE) begin
                prdata_ff[lpws_pkg::TIME_W-1:0] <= wake_ff[dec.fsp][dec.idx];
            end
        end
    end

    // =========================================================
    // Configuration checker
    // A shallower enabled state needs its next deeper state enabled
    assign pat_err = |(enable_ff[3:0] & ~enable_ff[4:1]); // see [R8] [R2]

    generate
        for (genvar f = 0; f < lpws_pkg::NUM_FSP; f++) begin : g_order
            logic ok;
            always_comb begin
                ok = 1'b1;
                for (int t = 0; t < lpws_pkg::NUM_TIMES; t++) begin
                    for (int u = 0; u < lpws_pkg::NUM_TIMES; u++) begin
                        if (group_of(3'(t)) < group_of(3'(u))
                            && wake_ff[f][t] >= wake_ff[f][u]) begin
                            ok = 1'b0; // see [R8]
                        end
                    end
                end
            end
            assign ord_err[f] = !ok;
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_err_ff <= 1'b0;
        end else begin
            cfg_err_ff <= pat_err || ord_err[fsp_ff];
        end
    end

    // =========================================================
    // Wakeup time selection for the requested state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_out_ff <= '0;
        end else begin
            wake_out_ff.valid <= lp_req;
            if (lp_req) begin
                wake_out_ff.enabled   <=
                    enable_ff[group_of(lp_kind)]; // see [R6]
                wake_out_ff.wake_time <=
                    eff_time(fsp_ff, lp_kind); // see [R7]
            end
        end
    end

    // =========================================================
    // Assertions
    property p_en_field;
        @(posedge pclk) disable iff (!presetn)
        (access && pwrite && dec.acc == lpws_pkg::LPWS_ACC_CTRL)
        |=> enable_ff == $past(pwdata[29:24]);
    endproperty
    a_en_field: assert property (p_en_field) // see [R1]
        else $error("enable field not taken from bits 29..24");

    property p_pattern;
        @(posedge pclk) disable iff (!presetn)
        (enable_ff[0] && !enable_ff[1]) ##1 (enable_ff[0] && !enable_ff[1])
        |-> cfg_err_ff;
    endproperty
    a_pattern: assert property (p_pattern) // see [R8]
        else $error("shallow enable without deeper enable not flagged");

    property p_depth;
        @(posedge pclk) disable iff (!presetn)
        (enable_ff[1] && !enable_ff[2]) |=> cfg_err_ff;
    endproperty
    a_depth: assert property (p_depth) // see [R2]
        else $error("state enabled with next deeper off not flagged");

    property p_shrink;
        @(posedge pclk) disable iff (!presetn)
        (lp_req && lp_kind == lpws_pkg::T_IDLE && enable_ff[1]
         && wake_ff[fsp_ff][1] < wake_ff[fsp_ff][0])
        |=> wake_out_ff.wake_time == $past(wake_ff[fsp_ff][1]);
    endproperty
    a_shrink: assert property (p_shrink) // see [R4]
        else $error("idle time not reduced to lower deeper time");

    property p_disabled;
        @(posedge pclk) disable iff (!presetn)
        (lp_req && lp_kind == lpws_pkg::T_CLKGATE && !enable_ff[4])
        |=> wake_out_ff.wake_time == ($past(wake_ff[fsp_ff][6]) >> 1);
    endproperty
    a_disabled: assert property (p_disabled) // see [R4]
        else $error("time not reduced when deeper state disabled");

    property p_group;
        @(posedge pclk) disable iff (!presetn)
        (lp_req && lp_kind >= lpws_pkg::T_SR_SHORT
         && lp_kind <= lpws_pkg::T_SRPD_LG)
        |=> wake_out_ff.valid && wake_out_ff.enabled == $past(enable_ff[2]);
    endproperty
    a_group: assert property (p_group) // see [R6]
        else $error("self refresh variant not tied to enable bit 2");

    property p_timer;
        @(posedge pclk) disable iff (!presetn)
        (lp_req && lp_kind == lpws_pkg::T_TIMER)
        |=> wake_out_ff.wake_time == $past(wake_ff[fsp_ff][7])
            && wake_out_ff.enabled == $past(enable_ff[4]);
    endproperty
    a_timer: assert property (p_timer) // see [R7]
        else $error("timer time not taken from active set point");

    property p_fsp_keep;
        @(posedge pclk) disable iff (!presetn)
        (access && pwrite && dec.acc == lpws_pkg::LPWS_ACC_CTRL
         && pwdata[lpws_pkg::FSP_MSB:lpws_pkg::FSP_LSB] == 2'h3)
        |=> fsp_ff == $past(fsp_ff);
    endproperty
    a_fsp_keep: assert property (p_fsp_keep) // see [R7]
        else $error("set point changed by a write of value 3");

    property p_idle_bit;
        @(posedge pclk) disable iff (!presetn)
        (lp_req && lp_kind == lpws_pkg::T_IDLE)
        |=> wake_out_ff.enabled == $past(enable_ff[0]);
    endproperty
    a_idle_bit: assert property (p_idle_bit) // see [R6]
        else $error("idle state not tied to enable bit 0");

    property p_order;
        @(posedge pclk) disable iff (!presetn)
        (wake_ff[fsp_ff][0] > wake_ff[fsp_ff][1])
        |=> cfg_err_ff;
    endproperty
    a_order: assert property (p_order) // see [R8]
        else $error("idle time above power-down time not flagged");

    property p_err_zero;
        @(posedge pclk) disable iff (!presetn)
        (pslverr_ff && !pwrite) |-> prdata_ff == 32'h0000_0000;
    endproperty
    a_err_zero: assert property (p_err_zero)
        else $error("refused read returned nonzero data");

endmodule // lpws_wakeup_select

//--- bench/lpws_seq_model.sv
// Sequencer-side partner that issues low-power entry requests
`timescale 1ns/1ps
module lpws_seq_model (
    // Clock
    input  wire logic       pclk,
    // Requests to the selector
    output logic            lp_req,
    output logic [2:0]      lp_kind
);
    initial begin
        lp_req  = 1'b0;
        lp_kind = 3'h0;
    end

    // One-cycle request pulse, changed just after a rising edge
    task automatic request(input logic [2:0] kind);
        @(posedge pclk);
        lp_req  <= 1'b1;
        lp_kind <= kind;
        @(posedge pclk);
        lp_req  <= 1'b0;
    endtask
endmodule // lpws_seq_model

//--- bench/dram_lowpower_wakeup_select_tb.sv
// Self-checking testbench of the low-power wakeup time selector
`timescale 1ns/1ps
module dram_lowpower_wakeup_select_tb;
    logic                 pclk, presetn, psel, penable, pwrite;
    logic [11:0]          paddr;
    logic [31:0]          pwdata, prdata_ff, rd;
    logic                 pready_ff, pslverr_ff, lp_req, cfg_err_ff, er;
    logic [2:0]           lp_kind;
    lpws_pkg::lpws_wake_t wake_out_ff;
    logic [7:0]           tm [3][8];
    int                   num_errors, checks_done;

    // ========================================================
    // Instances and clock
    lpws_wakeup_select dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata_ff(prdata_ff), .pready_ff(pready_ff),
        .pslverr_ff(pslverr_ff), .lp_req(lp_req), .lp_kind(lp_kind),
        .wake_out_ff(wake_out_ff), .cfg_err_ff(cfg_err_ff));
    lpws_seq_model seq_u (.pclk(pclk), .lp_req(lp_req), .lp_kind(lp_kind));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // ========================================================
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        if (num_errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready_ff !== 1'b1 && n < 20);
        if (n >= 20) begin
            num_errors++;
            finish_test();
        end
        rd = prdata_ff;
        er = pslverr_ff;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [11:0] wadr(input int f, input int i);
        return lpws_pkg::WAKE_BASE + 12'(f * 32 + i * 4);
    endfunction

    // Enable group of a wakeup time index
    function automatic int grp(input int i);
        return (i < 2) ? i : (i < 6) ? 2 : i - 3;
    endfunction

    function automatic logic ord_err(input int f);
        for (int i = 0; i < 8; i++)
            for (int j = 0; j < 8; j++)
                if (grp(i) < grp(j) && tm[f][i] >= tm[f][j]) return 1'b1;
        return 1'b0;
    endfunction

    // ========================================================
    // Select a set point and enables, then request every time
    task automatic sweep(input int f, input logic [5:0] en);
        logic [7:0] own, ref_t, ex;
        logic       pat;
        int         g;
        apb(1'b1, lpws_pkg::CTRL_OFS, {2'b00, en, 22'h0, 2'(f)});
        apb(1'b0, lpws_pkg::CTRL_OFS, 32'h0000_0000);
        chk(rd, {2'b00, en, 22'h0, 2'(f)});
        pat = 1'b0;
        for (int i = 0; i < 4; i++) pat |= en[i] & ~en[i+1];
        for (int k = 0; k < 8; k++) begin
            seq_u.request(3'(k));
            #1;
            g = grp(k);
            own = tm[f][k];
            ref_t = tm[f][(g < 2) ? g + 1 : (g == 2) ? 6 : 7];
            if (g == 4) ex = own;
            else if (!en[g+1]) ex = own >> 1;
            else if (ref_t < own) ex = ref_t;
            else ex = own;
            chk({22'h0, wake_out_ff}, {22'h0, 1'b1, en[g], ex});
        end
        chk({31'h0, cfg_err_ff}, {31'h0, pat | ord_err(f)});
        apb(1'b0, lpws_pkg::STATUS_OFS, 32'h0000_0000);
        chk(rd, {16'h0, ex, 4'h0, ord_err(2), ord_err(1), ord_err(0),
                 pat});
    endtask

    // ========================================================
    // Main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        num_errors = 0;
        checks_done = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        // All times zero after reset: not strictly rising, so flagged
        chk({21'h0, wake_out_ff, cfg_err_ff}, 32'h0000_0001);
        apb(1'b0, lpws_pkg::CTRL_OFS, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        apb(1'b0, wadr(1, 5), 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        // Fourth set point window and misaligned place are refused
        apb(1'b1, wadr(3, 0), 32'h0000_00ff);
        chk({31'h0, er}, 32'h0000_0001);
        apb(1'b0, wadr(3, 0), 32'h0000_0000);
        chk({er, rd[30:0]}, 32'h8000_0000);
        apb(1'b0, 12'h002, 32'h0000_0000);
        chk({31'h0, er}, 32'h0000_0001);
        // Times rise by depth, differ per set point; upper bits dropped
        for (int f = 0; f < 3; f++) begin
            for (int i = 0; i < 8; i++) begin
                tm[f][i] = 8'(i * 16 + f * 4 + 8);
                apb(1'b1, wadr(f, i), {24'hff_ffff, tm[f][i]});
            end
        end
        apb(1'b0, wadr(2, 7), 32'h0000_0000);
        chk(rd, {24'h0, tm[2][7]});
        sweep(0, 6'h1f);
        sweep(1, 6'h3e);
        // Idle on with power-down off, timer state off; then only self refresh off
        sweep(0, 6'h0d);
        sweep(2, 6'h1b);
        // A set point value of 3 keeps the old one
        apb(1'b1, lpws_pkg::CTRL_OFS, 32'h1f00_0003);
        apb(1'b0, lpws_pkg::CTRL_OFS, 32'h0000_0000);
        chk(rd, 32'h1f00_0002);
        // Power-down time below idle in set point 2
        tm[2][1] = 8'h01;
        apb(1'b1, wadr(2, 1), 32'h0000_0001);
        sweep(2, 6'h1f);
        finish_test();
    end
endmodule // dram_lowpower_wakeup_select_tb
